/* common/mtsm_pkg.sv */
// constants and carrier types for the motor temperature sensor monitor
// assumes one 20 MHz system clock and a front end that delivers ohms and deg C
package mtsm_pkg;
    localparam int TEMP_W = 10;
    localparam int OHM_W = 16;
    localparam int TYPE_W = 4;
    localparam int RESP_W = 4;
    localparam int ILIM_W = 16;

    // sensor type codes
    localparam logic [TYPE_W-1:0] TYPE_NONE = 4'h0;
    localparam logic [TYPE_W-1:0] TYPE_PTC = 4'h1;
    localparam logic [TYPE_W-1:0] TYPE_SILIN = 4'h2;
    localparam logic [TYPE_W-1:0] TYPE_BIMETAL = 4'h4;
    localparam logic [TYPE_W-1:0] TYPE_PT1K = 4'h6;

    // overtemperature response codes
    localparam logic [RESP_W-1:0] RESP_ALARM_ONLY = 4'h0;
    localparam logic [RESP_W-1:0] RESP_REDUCE = 4'h1;
    localparam logic [RESP_W-1:0] RESP_DEFAULT = 4'hc;

    // temperatures in deg C
    localparam logic signed [TEMP_W-1:0] ALARM_THR_RST = 10'sh082;
    localparam logic signed [TEMP_W-1:0] FAULT_THR_RST = 10'sh091;
    localparam logic signed [TEMP_W-1:0] TEMP_MIN = -10'sh030;
    localparam logic signed [TEMP_W-1:0] TEMP_MAX = 10'sh0f8;

    // resistances in ohm
    localparam logic [OHM_W-1:0] OHM_BREAK = 16'h0848;
    localparam logic [OHM_W-1:0] OHM_SI_SHORT = 16'h0032;
    localparam logic [OHM_W-1:0] OHM_PT_SHORT = 16'h025b;
    localparam logic [OHM_W-1:0] OHM_PTC_SHORT = 16'h0014;
    localparam logic [OHM_W-1:0] OHM_PTC_HOT = 16'h0672;
    localparam logic [OHM_W-1:0] OHM_SW_OPEN = 16'h0064;

    // escalation dwell
    localparam int CLK_HZ = 20000000;
    localparam int DWELL_MS = 100;
    localparam int DWELL_TICKS = DWELL_MS * (CLK_HZ / 1000);

    // current limit is halved on the reducing response
    localparam int ILIM_SHIFT = 1;

    typedef struct packed {
        logic valid;
        logic [OHM_W-1:0] ohm;
        logic signed [TEMP_W-1:0] temp;
    } mtsm_meas_t;

    typedef struct packed {
        logic [TYPE_W-1:0] sensor_type_select;
        logic [RESP_W-1:0] overtemp_response_select;
        logic signed [TEMP_W-1:0] temp_alarm_threshold;
        logic signed [TEMP_W-1:0] temp_fault_threshold;
    } mtsm_cfg_t;
endpackage : mtsm_pkg

/* rtl/mtsm_top.sv */
// motor overtemperature supervision for one selectable motor sensor
// assumes the front end delivers a resistance and a temperature with a valid
// strobe, synchronous to clk; settings arrive as a word with a write strobe
`timescale 1ns/100ps

module mtsm_top #(
    parameter int DWELL_CYCLES = mtsm_pkg::DWELL_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire mtsm_pkg::mtsm_cfg_t cfg_in,
    input wire mtsm_pkg::mtsm_meas_t meas,
    input wire logic fault_ack,
    input wire logic [mtsm_pkg::ILIM_W-1:0] output_current_limit,
    output mtsm_pkg::mtsm_cfg_t cfg_out,
    output logic signed [mtsm_pkg::TEMP_W-1:0] motor_temp,
    output logic motor_overtemp_alarm,
    output logic motor_overtemp_fault,
    output logic sensor_integrity_alarm,
    output logic sensor_integrity_fault,
    output logic current_limit_reduced,
    output logic [mtsm_pkg::ILIM_W-1:0] current_limit_applied
);
    import mtsm_pkg::*;

    localparam int CNT_W = $clog2(DWELL_CYCLES + 1);
    // the fault rises exactly DWELL_CYCLES edges after the alarm: the count runs
    // 1..DWELL_CYCLES while the condition stands, and the fault follows the last step
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DWELL_CYCLES);

    generate
        if (DWELL_CYCLES < 2) begin : g_bad_dwell
            $error("DWELL_CYCLES must be at least 2");
        end
        if (ILIM_SHIFT < 1 || ILIM_SHIFT >= ILIM_W) begin : g_bad_shift
            $error("ILIM_SHIFT must lie between 1 and ILIM_W - 1");
        end
    endgenerate

    // settings group
    // a write replaces the whole word, so the decode never sees old and new fields mixed
    mtsm_cfg_t cfg;
    mtsm_cfg_t next_cfg;
    always_comb begin
        next_cfg = cfg_wr ? cfg_in : cfg;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg.sensor_type_select <= TYPE_NONE;
            cfg.overtemp_response_select <= RESP_DEFAULT;
            cfg.temp_alarm_threshold <= ALARM_THR_RST;
            cfg.temp_fault_threshold <= FAULT_THR_RST;
        end else begin
            cfg <= next_cfg;
        end
    end

    // measurement group: last valid sample is held between strobes
    // limitation: a front end that stops strobing keeps the old reading in force,
    // so a stalled converter is not reported as a wire-break
    logic [OHM_W-1:0] ohm;
    logic signed [TEMP_W-1:0] temp;
    logic [OHM_W-1:0] next_ohm;
    logic signed [TEMP_W-1:0] next_temp;
    always_comb begin
        next_ohm = ohm;
        next_temp = temp;
        if (meas.valid) begin
            next_ohm = meas.ohm;
            next_temp = meas.temp;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ohm <= '0;
            temp <= '0;
        end else begin
            ohm <= next_ohm;
            temp <= next_temp;
        end
    end

    // sensor decode; unknown codes act as no sensor, the safe reading, except that only TYPE_NONE clears a latched integrity fault
    logic sel_ptc;
    logic sel_si;
    logic sel_sw;
    logic sel_pt;
    logic sel_lin;
    logic resp_zero;
    always_comb begin
        sel_ptc = cfg.sensor_type_select == TYPE_PTC;
        sel_si = cfg.sensor_type_select == TYPE_SILIN;
        sel_sw = cfg.sensor_type_select == TYPE_BIMETAL;
        sel_pt = cfg.sensor_type_select == TYPE_PT1K;
        sel_lin = sel_si | sel_pt;
        resp_zero = cfg.overtemp_response_select == RESP_ALARM_ONLY;
    end

    // temperature clamped to the valid span of the linear sensors
    logic signed [TEMP_W-1:0] lin_temp;
    always_comb begin
        if (temp < TEMP_MIN) begin
            lin_temp = TEMP_MIN;
        end else if (temp > TEMP_MAX) begin
            lin_temp = TEMP_MAX;
        end else begin
            lin_temp = temp;
        end
    end

    // condition evaluation for every sensor kind
    logic over_alarm_thr;
    logic hot;
    logic ot_alarm_cond;
    logic ot_fault_cond;
    logic integ_cond;
    always_comb begin
        over_alarm_thr = sel_lin && lin_temp > cfg.temp_alarm_threshold;
        // switch and PTC give a single hot indication, no temperature
        hot = (sel_sw && ohm >= OHM_SW_OPEN)
            || (sel_ptc && ohm > OHM_PTC_HOT);
        ot_alarm_cond = (over_alarm_thr && resp_zero)
            || hot;
        ot_fault_cond = (sel_lin && lin_temp > cfg.temp_fault_threshold)
            || (over_alarm_thr && !resp_zero)
            || (hot && !resp_zero);
        integ_cond = (sel_si && (ohm > OHM_BREAK || ohm < OHM_SI_SHORT))
            || (sel_pt && (ohm > OHM_BREAK || ohm < OHM_PT_SHORT))
            || (sel_ptc && ohm < OHM_PTC_SHORT);
        // no sensor selected leaves every sel_ term low, so all stay quiet
    end

    // escalation timer and integrity flags
    logic [CNT_W-1:0] dwell;
    logic [CNT_W-1:0] next_dwell;
    logic next_integ_alarm;
    logic next_integ_fault;
    always_comb begin
        next_integ_alarm = integ_cond;
        if (!integ_cond) begin
            next_dwell = '0;
        end else if (dwell != CNT_LAST) begin
            next_dwell = dwell + 1'b1;
        end else begin
            next_dwell = dwell;
        end
        // escalation wins over an acknowledge in the same cycle
        if (integ_cond && dwell == CNT_LAST) begin
            next_integ_fault = 1'b1;
        end else if (fault_ack || cfg.sensor_type_select == TYPE_NONE) begin
            next_integ_fault = 1'b0;
        end else begin
            next_integ_fault = sensor_integrity_fault;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dwell <= '0;
            sensor_integrity_alarm <= 1'b0;
            sensor_integrity_fault <= 1'b0;
        end else begin
            dwell <= next_dwell;
            sensor_integrity_alarm <= next_integ_alarm;
            sensor_integrity_fault <= next_integ_fault;
        end
    end

    // overtemperature outputs and current limit
    logic [ILIM_W-1:0] next_ilim;
    logic next_reduce;
    always_comb begin
        next_reduce = ot_fault_cond
            && cfg.overtemp_response_select == RESP_REDUCE;
        next_ilim = next_reduce ? (output_current_limit >> ILIM_SHIFT)
            : output_current_limit;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motor_overtemp_alarm <= 1'b0;
            motor_overtemp_fault <= 1'b0;
            current_limit_reduced <= 1'b0;
            current_limit_applied <= '0;
            motor_temp <= '0;
            cfg_out <= '0;
        end else begin
            motor_overtemp_alarm <= ot_alarm_cond;
            motor_overtemp_fault <= ot_fault_cond;
            current_limit_reduced <= next_reduce;
            current_limit_applied <= next_ilim;
            motor_temp <= sel_lin ? lin_temp : '0;
            cfg_out <= cfg;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_no_sensor_quiet: assert property (
        cfg.sensor_type_select == TYPE_NONE |=> !motor_overtemp_alarm && !motor_overtemp_fault
            && !sensor_integrity_alarm)
        else $error("alarm raised with no sensor selected");
    a_temp_span: assert property (
        sel_lin |=> motor_temp >= TEMP_MIN && motor_temp <= TEMP_MAX)
        else $error("motor temperature outside span");
    a_alarm_resp: assert property (
        motor_overtemp_alarm && $past(sel_lin) |-> $past(resp_zero)
            && $past(lin_temp) > $past(cfg.temp_alarm_threshold))
        else $error("overtemp alarm without cause");
    a_fault_thr: assert property (
        sel_lin && lin_temp > cfg.temp_fault_threshold |=> motor_overtemp_fault)
        else $error("fault threshold exceeded without fault");
    a_si_break: assert property (
        sel_si && ohm > OHM_BREAK |=> sensor_integrity_alarm)
        else $error("silicon wire break not flagged");
    a_pt_short: assert property (
        sel_pt && ohm < OHM_PT_SHORT |=> sensor_integrity_alarm)
        else $error("Pt1000 short not flagged");
    a_dwell_escal: assert property (
        $rose(sensor_integrity_fault) |-> $past(dwell) == CNT_LAST && $past(integ_cond))
        else $error("integrity fault before dwell elapsed");
    a_dwell_reset: assert property (
        !integ_cond |=> dwell == '0 && !sensor_integrity_alarm)
        else $error("dwell timer not restarted");
    a_sw_open: assert property (
        sel_sw && ohm >= OHM_SW_OPEN && !resp_zero |=> motor_overtemp_fault)
        else $error("open switch not reported");
    a_ptc_hot: assert property (
        sel_ptc && ohm > OHM_PTC_HOT |=> motor_overtemp_alarm)
        else $error("PTC overtemperature not reported");
    a_ilim_cut: assert property (
        current_limit_reduced |-> current_limit_applied
            == ($past(output_current_limit) >> ILIM_SHIFT))
        else $error("current limit not reduced");
    a_ilim_pass: assert property (
        !$past(rst) && !current_limit_reduced |-> current_limit_applied
            == $past(output_current_limit))
        else $error("current limit altered without reduction");

    // integrity limits not covered above
    a_si_short: assert property (
        sel_si && ohm < OHM_SI_SHORT |=> sensor_integrity_alarm)
        else $error("silicon short not flagged");
    a_pt_break: assert property (
        sel_pt && ohm > OHM_BREAK |=> sensor_integrity_alarm)
        else $error("Pt1000 wire break not flagged");
    a_ptc_short: assert property (
        sel_ptc && ohm < OHM_PTC_SHORT |=> sensor_integrity_alarm)
        else $error("PTC short not flagged");

    // clamping at both ends of the span
    a_si_clamp_low: assert property (
        sel_si && temp < TEMP_MIN |=> motor_temp == TEMP_MIN)
        else $error("silicon temperature not clamped low");
    a_pt_clamp_high: assert property (
        sel_pt && temp > TEMP_MAX |=> motor_temp == TEMP_MAX)
        else $error("Pt1000 temperature not clamped high");

    // responses of the threshold, switch and PTC paths
    a_resp_fault: assert property (
        over_alarm_thr && !resp_zero |=> motor_overtemp_fault && !motor_overtemp_alarm)
        else $error("nonzero response gave no fault");
    a_sw_alarm: assert property (
        sel_sw && ohm >= OHM_SW_OPEN |=> motor_overtemp_alarm)
        else $error("open switch gave no alarm");
    a_ptc_fault: assert property (
        sel_ptc && ohm > OHM_PTC_HOT && !resp_zero |=> motor_overtemp_fault)
        else $error("PTC overtemperature gave no fault");
    a_unknown_quiet: assert property (
        !(sel_ptc || sel_sw || sel_lin) |=> !motor_overtemp_alarm && !motor_overtemp_fault
            && !sensor_integrity_alarm)
        else $error("alarm raised for an unsupported sensor code");

    // settings and the latched integrity fault
    a_cfg_load: assert property (
        cfg_wr |=> cfg == $past(cfg_in))
        else $error("settings write not taken");
    a_none_clear: assert property (
        cfg.sensor_type_select == TYPE_NONE |=> !sensor_integrity_fault)
        else $error("integrity fault kept with no sensor");
    a_ack_clear: assert property (
        fault_ack && !(integ_cond && dwell == CNT_LAST) |=> !sensor_integrity_fault)
        else $error("acknowledge did not clear integrity fault");
    a_fault_hold: assert property (
        sensor_integrity_fault && !fault_ack && cfg.sensor_type_select != TYPE_NONE
            |=> sensor_integrity_fault)
        else $error("integrity fault dropped without acknowledge");

    c_break_escal: cover property (sel_si ##1 $rose(sensor_integrity_fault));
    c_ptc_short: cover property (sel_ptc && integ_cond ##1 sensor_integrity_alarm);
    c_alarm_only: cover property (resp_zero ##1 motor_overtemp_alarm && !motor_overtemp_fault);
    c_reduce: cover property ($rose(current_limit_reduced));
    c_ack_clear: cover property (sensor_integrity_fault && fault_ack ##1 !sensor_integrity_fault);
endmodule : mtsm_top

/* test/mtsm_fe_model.sv */
// front end model: hands the monitor one converted reading per clock
// assumes the bench sets the wanted reading and the enable between edges
`timescale 1ns/100ps
module mtsm_fe_model (
    input wire logic clk,
    input wire logic en,
    input wire logic [mtsm_pkg::OHM_W-1:0] ohm,
    input wire logic signed [mtsm_pkg::TEMP_W-1:0] temp,
    output mtsm_pkg::mtsm_meas_t meas
);
    import mtsm_pkg::*;
    logic [OHM_W-1:0] last_ohm = '0;
    logic signed [TEMP_W-1:0] last_temp = '0;
    // remember the last reading so the idle word can show its inverse
    always @(posedge clk) begin
        if (en) begin
            last_ohm <= ohm;
            last_temp <= temp;
        end
    end
    // follows the bench at once; the bench moves only on the falling edge, so the
    // monitor sees a settled word at each rising edge and no same-step race arises
    assign meas = en ? mtsm_meas_t'{1'b1, ohm, temp} : mtsm_meas_t'{1'b0, ~last_ohm, ~last_temp};
endmodule : mtsm_fe_model

/* test/mtsm_top_tb.sv */
// self-checking bench for the motor temperature sensor monitor
// assumes a short dwell parameter so escalation is seen in a few cycles
`timescale 1ns/100ps
module mtsm_top_tb;
    import mtsm_pkg::*;
    localparam int DW = 8;
    logic clk = 0, rst = 1, cfg_wr = 0, fault_ack = 0, en = 0;
    mtsm_cfg_t cfg_in = '0, cfg_out;
    mtsm_meas_t meas;
    logic [15:0] ohm = 16'h03e8, lim = 16'h0100, lim_q;
    logic signed [9:0] temp = 10'sh000, mtemp, at, ft;
    logic oa, of, ia, ifl, red;
    logic [3:0] tp, rs, fl;
    logic [15:0] crn [16][3];
    logic [3:0] types [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h3};
    logic [3:0] resps [4] = '{4'h0, 4'h1, 4'h2, 4'hc};
    int errors = 0, num_checks = 0, cyc = 0;

    mtsm_top #(.DWELL_CYCLES(DW)) dut_u (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
        .cfg_in(cfg_in), .meas(meas), .fault_ack(fault_ack), .output_current_limit(lim),
        .cfg_out(cfg_out), .motor_temp(mtemp), .motor_overtemp_alarm(oa),
        .motor_overtemp_fault(of), .sensor_integrity_alarm(ia),
        .sensor_integrity_fault(ifl), .current_limit_reduced(red),
        .current_limit_applied(lim_q));
    mtsm_fe_model fe_u (.clk(clk), .en(en), .ohm(ohm), .temp(temp), .meas(meas));

    always #25 clk = ~clk;
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic signed [9:0] clampt(input logic signed [9:0] t);
        return (t < TEMP_MIN) ? TEMP_MIN : (t > TEMP_MAX) ? TEMP_MAX : t;
    endfunction : clampt

    // expected {overtemp alarm, overtemp fault, integrity alarm, limit reduced}
    function automatic logic [3:0] flags(input logic [15:0] o, input logic signed [9:0] t);
        logic lin, hot, a, f, i;
        logic signed [9:0] c;
        lin = (tp == TYPE_SILIN) || (tp == TYPE_PT1K);
        c = clampt(t);
        hot = (tp == TYPE_PTC) ? (o > OHM_PTC_HOT) : (tp == TYPE_BIMETAL) && (o >= OHM_SW_OPEN);
        a = lin ? (c > at) && (rs == RESP_ALARM_ONLY) : hot;
        f = lin ? (c > ft) || ((c > at) && (rs != RESP_ALARM_ONLY)) : hot && (rs != 4'h0);
        i = lin ? (o > OHM_BREAK) || (o < ((tp == TYPE_SILIN) ? OHM_SI_SHORT : OHM_PT_SHORT))
            : (tp == TYPE_PTC) && (o < OHM_PTC_SHORT);
        return {a, f, i, f && (rs == RESP_REDUCE)};
    endfunction : flags

    task automatic setcfg(input logic [3:0] t, r, input logic signed [9:0] a, f);
        @(negedge clk);
        cfg_in = '{t, r, a, f};
        cfg_wr = 1'b1;
        {tp, rs, at, ft} = {t, r, a, f};
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : setcfg

    // reading is taken at the next edge and judged two edges later
    task automatic meas_chk(input logic [15:0] o, input logic signed [9:0] t);
        ohm = o;
        temp = t;
        en = 1'b1;
        repeat (3) @(negedge clk);
        fl = flags(o, t);
        chk({oa, of, ia, red}, fl);
        chk(mtemp, (tp == TYPE_SILIN || tp == TYPE_PT1K) ? clampt(t) : 10'sh000);
        chk(lim_q, fl[0] ? lim >> 1 : lim);
    endtask : meas_chk

    initial begin
        void'($urandom(96026));
        crn = '{'{2, 16'h0848, 16'h082}, '{2, 16'h0849, 16'h082}, '{2, 16'h0032, 16'h082},
            '{2, 16'h0031, 16'h082}, '{6, 16'h025b, 16'h083}, '{6, 16'h025a, 16'h091},
            '{6, 16'h0849, 16'h092}, '{1, 16'h0014, 0}, '{1, 16'h0013, 0}, '{1, 16'h0672, 0},
            '{1, 16'h0673, 0}, '{4, 16'h0063, 0}, '{4, 16'h0064, 0},
            '{2, 16'h03e8, 16'h3c4}, '{6, 16'h03e8, 16'h12c}, '{0, 16'h0849, 16'h12c}};
        repeat (11) @(negedge clk);
        chk({of, ia, ifl}, 3'h0);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(cfg_out, {TYPE_NONE, RESP_DEFAULT, ALARM_THR_RST, FAULT_THR_RST});
        // threshold and integrity boundaries
        foreach (crn[k]) begin
            setcfg(crn[k][0][3:0], 4'h2, ALARM_THR_RST, FAULT_THR_RST);
            meas_chk(crn[k][1], crn[k][2][9:0]);
        end
        // every type against every response with random thresholds and readings
        foreach (types[i]) foreach (resps[j]) begin
            setcfg(types[i], resps[j], 10'($urandom_range(200, 60)), 10'($urandom_range(220, 60)));
            lim = 16'($urandom);
            repeat (6) meas_chk((tp == TYPE_SILIN || tp == TYPE_PT1K) ?
                16'($urandom_range(2120, 603)) : 16'($urandom_range(3000, 0)),
                10'(int'($urandom_range(400, 0)) - 100));
        end
        // escalation: a short break, recovery, then a full dwell
        setcfg(TYPE_PT1K, 4'h2, ALARM_THR_RST, FAULT_THR_RST);
        fault_ack = 1'b1;
        meas_chk(16'h03e8, 10'sh020);
        fault_ack = 1'b0;
        ohm = 16'h0900;
        repeat (5) @(negedge clk);
        ohm = 16'h03e8;
        repeat (3) @(negedge clk);
        chk({ia, ifl}, 2'b00);
        ohm = 16'h0900;
        repeat (3) @(negedge clk);
        chk({ia, ifl}, 2'b10);
        repeat (DW - 2) @(negedge clk);
        chk(ifl, 1'b0);
        @(negedge clk);
        chk(ifl, 1'b1);
        ohm = 16'h03e8;
        repeat (3) @(negedge clk);
        chk({ia, ifl}, 2'b01);
        fault_ack = 1'b1;
        @(negedge clk);
        fault_ack = 1'b0;
        @(negedge clk);
        chk(ifl, 1'b0);
        close_out();
    end
endmodule : mtsm_top_tb
